// File: dv/rghc_cpu_model.sv
// Purpose: CPU core model that issues register writes and halt.
// Assumes: Called from the bench; changes pins just after a rising edge.
// Notes: sel_o bits are guarded, key a, key b, control; none is memory.
`timescale 1ns/1ps
module rghc_cpu_model (
  input wire logic sys_clk_i,
  output logic wr_en_o,
  output logic [23:0] wr_addr_o,
  output logic [3:0] sel_o,
  output logic [7:0] wr_data_o,
  output logic halt_o
);
  initial begin
    wr_en_o = 1'b0;
    wr_addr_o = 24'h000000;
    sel_o = 4'h0;
    wr_data_o = 8'h00;
    halt_o = 1'b0;
  end
  task automatic wr(input logic [3:0] s, input logic [23:0] a,
      input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_en_o <= 1'b1;
    sel_o <= s;
    wr_addr_o <= a;
    wr_data_o <= d;
  endtask : wr
  // A released bus shows the inverse of its last value.
  task automatic idle();
    @(posedge sys_clk_i);
    wr_en_o <= 1'b0;
    halt_o <= 1'b0;
    sel_o <= 4'h0;
    wr_addr_o <= ~wr_addr_o;
    wr_data_o <= ~wr_data_o;
  endtask : idle
  task automatic halt();
    @(posedge sys_clk_i);
    halt_o <= 1'b1;
  endtask : halt
  // The two key bytes go out on consecutive cycles.
  task automatic key_pair(input logic [7:0] k1, input logic [7:0] k2);
    wr(4'h2, 24'h000000, k1);
    wr(4'h4, 24'h000000, k2);
    idle();
  endtask : key_pair
endmodule : rghc_cpu_model

// File: dv/rghc_tb_top.sv
// Purpose: Self-checking bench for the runaway guard and halt control.
// Assumes: Warm-up shortened to WU cycles; interrupt mask fixed at 3.
// Notes: Pulses are counted by a monitor, then compared as deltas.
`timescale 1ns/1ps
module rghc_tb_top;
  import rghc_pkg::*;
  localparam int unsigned WU = 8;
  typedef struct packed {
    logic [3:0] s;
    logic [23:0] a;
    logic [7:0] d;
    logic [1:0] ev;
    logic [2:0] f;
  } rghc_row_t;
  logic clk, rst, wr_en, halt, ok, viol, romi, prot, ext, amp, pin, res, srv;
  logic cpu, sck, osc, rtc, lcd, hold;
  logic srv_seen = 1'b0;
  logic [23:0] addr;
  logic [3:0] sel;
  logic [7:0] data;
  logic [2:0] lvl, hit;
  logic [10:0] irq;
  logic [6:0] run_en, urun;
  logic [1:0] hsel;
  int n_fail = 0, checked = 0, n_ok = 0, n_viol = 0, n_rom = 0, n_res = 0;
  int cyc = 0;
  rghc_row_t rows[10] = '{
    '{4'h1, 24'h000000, 8'h00, 2'b00, 3'b000},
    '{4'h8, 24'h000000, 8'hCE, 2'b00, 3'b000},
    '{4'h0, 24'h400000, 8'h11, 2'b10, 3'b001},
    '{4'h0, 24'h7FFFFF, 8'h11, 2'b10, 3'b001},
    '{4'h0, 24'h3FFFFF, 8'h11, 2'b00, 3'b001},
    '{4'h0, 24'h800000, 8'h11, 2'b10, 3'b011},
    '{4'h0, 24'hFFFFFF, 8'h11, 2'b10, 3'b111},
    '{4'h8, 24'h000000, 8'hE8, 2'b00, 3'b110},
    '{4'h0, 24'hBFFFFF, 8'h11, 2'b00, 3'b110},
    '{4'h0, 24'hC00000, 8'h11, 2'b10, 3'b110}};
  rghc_cpu_model u (.sys_clk_i(clk), .wr_en_o(wr_en), .wr_addr_o(addr),
    .sel_o(sel), .wr_data_o(data), .halt_o(halt));
  rghc_top #(.WARMUP_CYCLES(WU)) dut (.sys_clk_i(clk), .sys_rst_i(rst),
    .wr_en_i(wr_en), .wr_addr_i(addr), .guarded_sel_i(sel[0]),
    .key_a_sel_i(sel[1]), .key_b_sel_i(sel[2]), .ctrl_sel_i(sel[3]),
    .wr_data_i(data), .halt_i(halt), .irq_mask_level_i(3'h3),
    .irq_level_i(lvl), .nmi_i(irq[0]), .watchdog_irq_i(irq[1]),
    .alarm_irqs_i(irq[2]), .timer_irqs_i(irq[3]), .serial_irqs_i(irq[4]),
    .adc_irq_i(irq[5]), .serial_bus_irq_i(irq[6]), .lcd_irq_i(irq[7]),
    .rtc_irq_i(irq[8]), .key_irq_i(irq[9]), .ext_pin_irqs_i(irq[10]),
    .halt_run_en_i(run_en), .guarded_wr_ok_o(ok),
    .prot_violation_irq_o(viol), .rom_write_irq_o(romi), .protect_o(prot),
    .ext_clock_input_sel_o(ext), .osc_amp_en_o(amp), .osc_out_pin_o(pin),
    .flash_region_hit_o(hit[0]), .data_region_hit_o(hit[1]),
    .prog_region_hit_o(hit[2]), .halt_sel_o(hsel), .cpu_run_o(cpu),
    .sys_clk_en_o(sck), .osc_en_o(osc), .rtc_run_o(rtc),
    .lcd_intc_run_o(lcd), .port_hold_o(hold), .unit_run_o(urun),
    .resume_o(res), .resume_service_o(srv));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    n_ok += (ok === 1'b1);
    n_viol += (viol === 1'b1);
    n_rom += (romi === 1'b1);
    n_res += (res === 1'b1);
    if (res === 1'b1) srv_seen = srv;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string m);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    settle(5);
    rst <= 1'b0;
    settle(1);
    chk({prot, ext, amp, pin, hit, hsel, cpu, sck, osc, rtc},
      13'h043F, "reset");
  endtask : do_reset
  task automatic op(input logic [3:0] s, input logic [23:0] a,
      input logic [7:0] d, input logic [1:0] ev, input logic [2:0] f);
    int o, v, r;
    o = n_ok;
    v = n_viol;
    r = n_rom;
    u.wr(s, a, d);
    u.idle();
    settle(3);
    chk(n_rom - r, ev[1], "rom irq");
    chk(n_viol - v, ev[0], "violation");
    if (s == 4'h1) chk(n_ok - o, !ev[0], "guarded ok");
    chk(hit, f, "flags");
  endtask : op
  task automatic key(input logic [7:0] k1, input logic [7:0] k2,
      input logic e);
    u.key_pair(k1, k2);
    settle(2);
    chk(prot, e, "protect");
  endtask : key
  task automatic rel(input int s, input logic [2:0] l, input logic er,
      input logic es, input logic [1:0] m);
    int r, w;
    r = n_res;
    w = 0;
    @(posedge clk);
    lvl <= l;
    irq[s] <= 1'b1;
    while (n_res == r && w < 40) begin
      settle(1);
      w++;
    end
    @(posedge clk);
    irq <= 11'h000;
    chk(n_res - r, er, "release");
    if (er) chk({srv_seen, w >= WU || m != HSEL_STOP}, {es, 1'b1},
      "service");
  endtask : rel
  task automatic hc(input logic [1:0] m, input int s, input logic [2:0] l,
      input logic er, input logic es);
    logic [3:0] e;
    e = (m == HSEL_CPU_ONLY_HALT) ? 4'h7 : (m == HSEL_OSC_RTC_HALT) ? 4'h3 : 4'h0;
    op(4'h8, 24'h000000, {m, 6'h00}, 2'b00, 3'b000);
    chk(hsel, m, "field");
    u.halt();
    u.idle();
    settle(2);
    chk({cpu, sck, osc, rtc}, e, "halt");
    chk({lcd, hold, urun}, (m == HSEL_CPU_ONLY_HALT) ? {2'b11, run_en} : 9'h000,
      "units");
    rel(s, l, er, es, m);
    if (!er) rel(0, 3'h7, 1'b1, 1'b1, m);
    settle(4);
    chk({cpu, hsel}, {1'b1, m}, "after");
  endtask : hc
  task automatic report_and_stop();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    rst = 1'b1;
    lvl = 3'h0;
    irq = 11'h000;
    run_en = 7'h55;
    do_reset();
    foreach (rows[i]) op(rows[i].s, rows[i].a, rows[i].d, rows[i].ev,
      rows[i].f);
    key(8'h5A, 8'hA5, 1'b1);
    op(4'h1, 24'h000000, 8'h00, 2'b01, 3'b110);
    op(4'h8, 24'h000000, 8'h00, 2'b01, 3'b000);
    chk(hsel, 2'b11, "locked field");
    u.wr(4'h2, 24'h000000, 8'hA5);
    u.idle();
    u.wr(4'h4, 24'h000000, 8'h5A);
    u.idle();
    settle(2);
    chk(prot, 1'b1, "split key");
    key(8'h5A, 8'h5A, 1'b1);
    key(8'hA5, 8'h5A, 1'b0);
    op(4'h8, 24'h000000, 8'hC1, 2'b00, 3'b000);
    chk({ext, amp, pin}, 3'b101, "ext clock");
    hc(2'b11, 3, 3'h5, 1'b1, 1'b1);
    hc(2'b11, 3, 3'h3, 1'b1, 1'b1);
    hc(2'b11, 3, 3'h1, 1'b0, 1'b0);
    hc(2'b11, 1, 3'h5, 1'b1, 1'b1);
    hc(2'b10, 1, 3'h5, 1'b0, 1'b0);
    hc(2'b10, 7, 3'h5, 1'b0, 1'b0);
    hc(2'b10, 8, 3'h1, 1'b1, 1'b0);
    hc(2'b10, 10, 3'h1, 1'b1, 1'b0);
    hc(2'b01, 9, 3'h5, 1'b1, 1'b1);
    hc(2'b01, 2, 3'h5, 1'b0, 1'b0);
    hc(2'b01, 8, 3'h5, 1'b0, 1'b0);
    hc(2'b01, 10, 3'h1, 1'b1, 1'b0);
    op(4'h8, 24'h000000, 8'hC1, 2'b00, 3'b000);
    key(8'h5A, 8'hA5, 1'b1);
    u.halt();
    u.idle();
    do_reset();
    report_and_stop();
  end
endmodule : rghc_tb_top

// File: logic/rghc_key_if.sv
// Purpose: Key-register write events passed to the key sequencer.
// Assumes: Same clock as the top.
// Notes: Pulses last one cycle.
`timescale 1ns/1ps
interface rghc_key_if;
  logic wr_a;
  logic wr_b;
  logic wr_other;
  logic [7:0] data;
  logic prot;
  modport top (output wr_a, output wr_b, output wr_other, output data,
    input prot);
  modport seq (input wr_a, input wr_b, input wr_other, input data,
    output prot);
endinterface : rghc_key_if

// File: logic/rghc_key_seq.sv
// Purpose: Double-key protection state machine.
// Assumes: Key writes arrive as one-cycle strobes.
// Notes: Key b must come on the cycle right after key a; any cycle between the two keys breaks the sequence.
`timescale 1ns/1ps
module rghc_key_seq
  import rghc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  rghc_key_if.seq k
);
  logic prot_reg, prot_next;
  logic [1:0] arm_reg, arm_next;
  always_comb begin
    prot_next = prot_reg;
    arm_next = 2'h0;
    if (k.wr_a) begin
      if (k.data == KEY_5A) arm_next = 2'h1;
      else if (k.data == KEY_A5) arm_next = 2'h2;
    end else if (k.wr_b) begin
      if (arm_reg == 2'h1 && k.data == KEY_A5) prot_next = 1'b1;
      if (arm_reg == 2'h2 && k.data == KEY_5A) prot_next = 1'b0;
    end else if (!k.wr_other) begin
      arm_next = 2'h0;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prot_reg <= 1'b0;
      arm_reg <= 2'h0;
    end else begin
      prot_reg <= prot_next;
      arm_reg <= arm_next;
    end
  end
  assign k.prot = prot_reg;
  AST_KEY_ON: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (k.wr_a && k.data == KEY_5A) ##1 (k.wr_b && k.data == KEY_A5)
    |=> prot_reg) else $error("protection not set by key");
  AST_KEY_OFF: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (k.wr_a && k.data == KEY_A5) ##1 (k.wr_b && k.data == KEY_5A)
    |=> !prot_reg) else $error("protection not cleared by key");
  AST_KEY_HOLD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !k.wr_b |=> $stable(prot_reg)) else $error("protection changed");
endmodule : rghc_key_seq

// File: logic/rghc_pkg.sv
// Purpose: Shared constants and types for the runaway guard and halt control.
// Assumes: One 50 MHz system clock, synchronous active-high reset.
// Notes: Register indices are local to this block.
package rghc_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam logic [7:0] KEY_5A = 8'h5A;
  localparam logic [7:0] KEY_A5 = 8'hA5;
  localparam logic [23:0] FLASH_BASE = 24'h400000;
  localparam logic [23:0] FLASH_LAST = 24'h7FFFFF;
  localparam logic [23:0] DATA_BASE = 24'h800000;
  localparam logic [23:0] DATA_LAST = 24'hBFFFFF;
  localparam logic [23:0] PROG_BASE = 24'hC00000;
  localparam logic [23:0] PROG_LAST = 24'hFFFFFF;
  localparam logic [2:0] NMI_LEVEL = 3'h7;
  localparam logic [1:0] HSEL_CPU_ONLY_HALT = 2'h3;
  localparam logic [1:0] HSEL_OSC_RTC_HALT = 2'h2;
  localparam logic [1:0] HSEL_STOP = 2'h1;
  localparam int unsigned WARMUP_US = 10000;
  localparam int unsigned WARMUP_CYC = WARMUP_US * (CLK_HZ / 1000000);
  localparam int unsigned NRUN = 7;
  typedef enum logic [1:0] {
    RGHC_RUN = 2'b00,
    RGHC_HALT = 2'b01,
    RGHC_WARM = 2'b10
  } rghc_state_t;
endpackage : rghc_pkg

// File: logic/rghc_top.sv
// Purpose: Runaway guard, ROM write detect and halt control.
// Assumes: CPU gives one-cycle write strobes and a halt strobe.
// Notes: Outputs are registered; run enables are one bit per unit.
`timescale 1ns/1ps
module rghc_top
  import rghc_pkg::*;
#(
  parameter int unsigned WARMUP_CYCLES = WARMUP_CYC
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire logic [23:0] wr_addr_i,
  input wire logic guarded_sel_i,
  input wire logic key_a_sel_i,
  input wire logic key_b_sel_i,
  input wire logic ctrl_sel_i,
  input wire logic [7:0] wr_data_i,
  input wire logic halt_i,
  input wire logic [2:0] irq_mask_level_i,
  input wire logic [2:0] irq_level_i,
  input wire logic nmi_i,
  input wire logic watchdog_irq_i,
  input wire logic alarm_irqs_i,
  input wire logic timer_irqs_i,
  input wire logic serial_irqs_i,
  input wire logic adc_irq_i,
  input wire logic serial_bus_irq_i,
  input wire logic lcd_irq_i,
  input wire logic rtc_irq_i,
  input wire logic key_irq_i,
  input wire logic ext_pin_irqs_i,
  input wire logic [NRUN-1:0] halt_run_en_i,
  output logic guarded_wr_ok_o,
  output logic prot_violation_irq_o,
  output logic rom_write_irq_o,
  output logic protect_o,
  output logic ext_clock_input_sel_o,
  output logic osc_amp_en_o,
  output logic osc_out_pin_o,
  output logic flash_region_hit_o,
  output logic data_region_hit_o,
  output logic prog_region_hit_o,
  output logic [1:0] halt_sel_o,
  output logic cpu_run_o,
  output logic sys_clk_en_o,
  output logic osc_en_o,
  output logic rtc_run_o,
  output logic lcd_intc_run_o,
  output logic port_hold_o,
  output logic [NRUN-1:0] unit_run_o,
  output logic resume_o,
  output logic resume_service_o
);
  rghc_key_if kif();
  assign kif.wr_a = wr_en_i && key_a_sel_i;
  assign kif.wr_b = wr_en_i && key_b_sel_i;
  assign kif.wr_other = wr_en_i && !key_a_sel_i && !key_b_sel_i;
  assign kif.data = wr_data_i;
  rghc_key_seq u_key (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .k(kif)
  );

  // Control register, bit map: 0 ext clock, 1-3 region enables,
  // 4-6 hit flags (write zero clears), 6-7 halt field.  Halt field shares ctrl
  // writes with ext clock and region enables; all three are blocked while protect is set.
  logic ext_reg, ext_next;
  logic [2:0] en_reg, en_next;
  logic [2:0] hit_reg, hit_next;
  logic [1:0] hsel_reg, hsel_next;
  logic viol_reg, viol_next;
  logic romirq_reg, romirq_next;
  logic wok_reg, wok_next;
  logic [2:0] reg_hit;
  logic ctrl_wr;

  assign ctrl_wr = wr_en_i && ctrl_sel_i;
  always_comb begin
    reg_hit[0] = wr_addr_i >= FLASH_BASE && wr_addr_i <= FLASH_LAST;
    reg_hit[1] = wr_addr_i >= DATA_BASE && wr_addr_i <= DATA_LAST;
    reg_hit[2] = wr_addr_i >= PROG_BASE && wr_addr_i <= PROG_LAST;
  end

  always_comb begin
    logic [2:0] ev;
    ev = 3'h0;
    ext_next = ext_reg;
    en_next = en_reg;
    hit_next = hit_reg;
    hsel_next = hsel_reg;
    wok_next = 1'b0;
    viol_next = 1'b0;
    if (wr_en_i && (guarded_sel_i || ctrl_sel_i) && kif.prot) begin
      viol_next = 1'b1;
    end
    if (wr_en_i && guarded_sel_i && !kif.prot) wok_next = 1'b1;
    if (ctrl_wr && !kif.prot) begin
      ext_next = wr_data_i[0];
      en_next = wr_data_i[3:1];
      hsel_next = wr_data_i[7:6];
    end
    if (ctrl_wr) begin
      hit_next = hit_reg & wr_data_i[6:4];
    end
    if (wr_en_i && !guarded_sel_i && !key_a_sel_i && !key_b_sel_i &&
        !ctrl_sel_i) begin
      ev = reg_hit & en_reg;
    end
    hit_next = hit_next | ev;
    romirq_next = |ev;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ext_reg <= 1'b0;
      en_reg <= 3'h0;
      hit_reg <= 3'h0;
      hsel_reg <= HSEL_CPU_ONLY_HALT;
      viol_reg <= 1'b0;
      romirq_reg <= 1'b0;
      wok_reg <= 1'b0;
    end else begin
      ext_reg <= ext_next;
      en_reg <= en_next;
      hit_reg <= hit_next;
      hsel_reg <= hsel_next;
      viol_reg <= viol_next;
      romirq_reg <= romirq_next;
      wok_reg <= wok_next;
    end
  end

  // Halt sequencing.
  rghc_state_t st_reg, st_next;
  logic [1:0] mode_reg, mode_next;
  logic [31:0] wcnt_reg, wcnt_next;
  logic res_reg, res_next;
  logic srv_reg, srv_next;
  logic [NRUN-1:0] run_reg, run_next;
  logic unmasked, rel_srv, rel_nosrv;

  assign unmasked = irq_level_i >= irq_mask_level_i;
  always_comb begin
    rel_srv = 1'b0;
    rel_nosrv = 1'b0;
    case (mode_reg)
      HSEL_CPU_ONLY_HALT: begin
        rel_srv = unmasked && (watchdog_irq_i || alarm_irqs_i ||
          timer_irqs_i || serial_irqs_i || adc_irq_i || serial_bus_irq_i ||
          lcd_irq_i || rtc_irq_i || key_irq_i || ext_pin_irqs_i);
        rel_nosrv = !unmasked && (ext_pin_irqs_i || rtc_irq_i ||
          alarm_irqs_i || key_irq_i);
      end
      HSEL_OSC_RTC_HALT: begin
        rel_nosrv = ext_pin_irqs_i || rtc_irq_i || alarm_irqs_i ||
          key_irq_i;
      end
      HSEL_STOP: begin
        rel_srv = unmasked && key_irq_i;
        rel_nosrv = (!unmasked && key_irq_i) || ext_pin_irqs_i;
      end
      default: begin
        rel_srv = 1'b0;
        rel_nosrv = 1'b0;
      end
    endcase
    if (nmi_i) begin
      rel_srv = 1'b1;
      rel_nosrv = 1'b0;
    end
  end

  always_comb begin
    st_next = st_reg;
    mode_next = mode_reg;
    wcnt_next = wcnt_reg;
    res_next = 1'b0;
    srv_next = 1'b0;
    run_next = run_reg;
    case (st_reg)
      RGHC_RUN: begin
        if (halt_i && hsel_reg != 2'h0) begin
          st_next = RGHC_HALT;
          mode_next = hsel_reg;
          run_next = (hsel_reg == HSEL_CPU_ONLY_HALT) ? halt_run_en_i :
            {NRUN{1'b0}};
        end else begin
          run_next = {NRUN{1'b1}};
        end
      end
      RGHC_HALT: begin
        if (rel_srv || rel_nosrv) begin
          if (mode_reg == HSEL_STOP) begin
            st_next = RGHC_WARM;
            wcnt_next = 32'h0;
            srv_next = rel_srv;
            res_next = 1'b0;
          end else begin
            st_next = RGHC_RUN;
            res_next = 1'b1;
            srv_next = rel_srv;
            run_next = {NRUN{1'b1}};
          end
        end
      end
      RGHC_WARM: begin
        srv_next = srv_reg;
        wcnt_next = wcnt_reg + 32'h1;
        if (wcnt_reg >= WARMUP_CYCLES - 1) begin
          st_next = RGHC_RUN;
          res_next = 1'b1;
          run_next = {NRUN{1'b1}};
        end
      end
      default: st_next = RGHC_RUN;
    endcase
    if (st_reg == RGHC_RUN) srv_next = 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_reg <= RGHC_RUN;
      mode_reg <= 2'h0;
      wcnt_reg <= 32'h0;
      res_reg <= 1'b0;
      srv_reg <= 1'b0;
      run_reg <= {NRUN{1'b1}};
    end else begin
      st_reg <= st_next;
      mode_reg <= mode_next;
      wcnt_reg <= wcnt_next;
      res_reg <= res_next;
      srv_reg <= (st_next == RGHC_RUN) ? (res_next & srv_next) : srv_next;
      run_reg <= run_next;
    end
  end

  // Run and pin controls are decoded from the next state, so each output
  // comes straight from a flop with no extra cycle of lag.
  logic halted_next;
  logic amp_reg, amp_next, cpu_reg, cpu_next, sck_reg, sck_next;
  logic osc_reg, osc_next, rtcr_reg, rtcr_next;
  logic lcd_reg, lcd_next, hold_reg, hold_next;

  always_comb begin
    halted_next = st_next != RGHC_RUN;
    amp_next = !ext_next;
    cpu_next = !halted_next;
    sck_next = !(halted_next && mode_next != HSEL_CPU_ONLY_HALT);
    osc_next = !(halted_next && mode_next == HSEL_STOP) ||
      st_next == RGHC_WARM;
    rtcr_next = !(st_next == RGHC_HALT && mode_next == HSEL_STOP);
    lcd_next = !(halted_next && mode_next != HSEL_CPU_ONLY_HALT);
    hold_next = halted_next && mode_next == HSEL_CPU_ONLY_HALT;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      amp_reg <= 1'b1;
      cpu_reg <= 1'b1;
      sck_reg <= 1'b1;
      osc_reg <= 1'b1;
      rtcr_reg <= 1'b1;
      lcd_reg <= 1'b1;
      hold_reg <= 1'b0;
    end else begin
      amp_reg <= amp_next;
      cpu_reg <= cpu_next;
      sck_reg <= sck_next;
      osc_reg <= osc_next;
      rtcr_reg <= rtcr_next;
      lcd_reg <= lcd_next;
      hold_reg <= hold_next;
    end
  end

  logic halted;
  assign halted = st_reg != RGHC_RUN;
  assign guarded_wr_ok_o = wok_reg;
  assign prot_violation_irq_o = viol_reg;
  assign rom_write_irq_o = romirq_reg;
  assign protect_o = kif.prot;
  assign ext_clock_input_sel_o = ext_reg;
  assign osc_amp_en_o = amp_reg;
  assign osc_out_pin_o = ext_reg;
  assign flash_region_hit_o = hit_reg[0];
  assign data_region_hit_o = hit_reg[1];
  assign prog_region_hit_o = hit_reg[2];
  assign halt_sel_o = hsel_reg;
  assign cpu_run_o = cpu_reg;
  assign sys_clk_en_o = sck_reg;
  assign osc_en_o = osc_reg;
  assign rtc_run_o = rtcr_reg;
  assign lcd_intc_run_o = lcd_reg;
  assign port_hold_o = hold_reg;
  assign unit_run_o = run_reg;
  assign resume_o = res_reg;
  assign resume_service_o = srv_reg;

  AST_VIOL: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_en_i && guarded_sel_i && kif.prot) |=> prot_violation_irq_o &&
    !guarded_wr_ok_o) else $error("violation missing");
  AST_ROMIRQ: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    rom_write_irq_o |-> (|hit_reg)) else $error("rom irq without flag");
  AST_EXTPIN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ext_clock_input_sel_o |-> osc_out_pin_o && !osc_amp_en_o)
    else $error("ext clock pin wrong");
  AST_HALT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (st_reg == RGHC_RUN && halt_i && hsel_reg == HSEL_STOP) |=>
    !osc_en_o && !cpu_run_o) else $error("stop not entered");
  AST_NMI: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (st_reg == RGHC_HALT && nmi_i && mode_reg != HSEL_STOP) |=>
    resume_o && resume_service_o) else $error("nmi no release");
  AST_WARM: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (st_reg == RGHC_WARM) |-> !resume_o) else $error("early resume");
  AST_OSC_RTC_HALT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (halted && mode_reg == HSEL_OSC_RTC_HALT) |-> !sys_clk_en_o && osc_en_o)
    else $error("osc_rtc_halt clocks wrong");
  AST_HITSET: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(rom_write_irq_o) |-> !$stable(hit_reg) || $past(hit_reg) != 3'h0)
    else $error("hit flag not set");
endmodule : rghc_top
